// File: pc_stack_regs.vh
// Register offsets, fields, reset values and sizes of the program counter and return stack
// Notes on behaviour
// [RULE1] Counter is 21 bits over three bytes
// [RULE2] Low byte readable and writable by software
// [RULE3] High byte changes only via high latch
// [RULE4] Upper byte changes only via upper latch
// [RULE5] Low byte write loads latches into counter
// [RULE6] Low byte read copies counter into latches
// [RULE7] Counter bit zero always reads zero
// [RULE8] Sequential fetch advances counter by two
// [RULE9] Jumps load target, latches not used
// [RULE10] Up to 31 nested calls or interrupts
// [RULE11] Calls and interrupts push, returns pop
// [RULE12] Calls and returns leave latches alone
// [RULE13] 31 by 21 storage, 5-bit pointer
// [RULE14] Software reads/writes pointer and top entry
// [RULE15] Push: increment pointer, then store counter
// [RULE16] Pop: load counter, then decrement pointer
// [RULE17] Reset clears pointer; entry zero has no storage
// [RULE18] Overflow and underflow flags in power status
// [RULE19] Three top registers show addressed entry
// [RULE20] Software masks interrupts around stack access
// [RULE21] Top registers follow every pointer change
`ifndef PC_STACK_REGS_VH
`define PC_STACK_REGS_VH

`define PC_WIDTH          21
`define SP_WIDTH          5
`define STACK_DEPTH       31

`define REG_PC_LOW        4'h0
`define REG_PC_HIGH_LATCH 4'h1
`define REG_PC_UPPER_LATCH 4'h2
`define REG_STACK_PTR     4'h3
`define REG_TOS_LOW       4'h4
`define REG_TOS_HIGH      4'h5
`define REG_TOS_UPPER     4'h6
`define REG_POWER_STATUS  4'h7
`define REG_PC_FULL       4'h8

`define STAT_OVF_BIT      7
`define STAT_UNF_BIT      6

`define PC_RESET          21'h00_0000
`define SP_RESET          5'h00
`define STAT_RESET        8'h00

`endif

// File: stack_ram.v
// Return stack storage: 31 entries of 21 bits with registered read data
`timescale 1ns/1ps
module stack_ram #(
   parameter WIDTH = 21,
   parameter AW    = 5,
   parameter DEPTH = 31
) (
   // Clock
   input  wire             mclk,
   // Write port
   input  wire             wr_en,
   input  wire [AW-1:0]    wr_addr,
   input  wire [WIDTH-1:0] wr_data,
   // Read port
   input  wire [AW-1:0]    rd_addr,
   output reg  [WIDTH-1:0] rd_data
);
   reg [WIDTH-1:0] mem [1:DEPTH];

   // Address zero has no storage; writes there are dropped
   always @(posedge mclk) begin
      if (wr_en && wr_addr != {AW{1'b0}})
         mem[wr_addr] <= wr_data;
   end

   // Registered read, with write-through so a fresh entry shows at once
   always @(posedge mclk) begin
      if (rd_addr == {AW{1'b0}})
         rd_data <= {WIDTH{1'b0}};
      else if (wr_en && wr_addr == rd_addr)
         rd_data <= wr_data;
      else
         rd_data <= mem[rd_addr];
   end
endmodule // stack_ram

// File: pc_return_stack.v
// Program counter with latches and return address stack, Avalon-MM register slave
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "pc_stack_regs.vh"
module pc_return_stack (
   // Clock and reset
   input  wire        mclk,
   input  wire        rst,
   // Avalon-MM slave
   input  wire [5:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // Core fetch, branch and interrupt controls
   input  wire        core_advance,
   input  wire        core_jump,
   input  wire [20:0] core_target,
   input  wire        core_call,
   input  wire        core_irq_ack,
   input  wire        core_return,
   // Core view
   output wire [20:0] pc,
   output wire [4:0]  stack_pointer,
   output wire        stack_overflow,
   output wire        stack_underflow
);
   // State of the counter, latches, pointer and status
   reg  [20:0] pc_reg;
   reg  [7:0]  pc_high_latch;
   reg  [7:0]  pc_upper_latch;
   reg  [4:0]  stack_pointer_reg;
   reg  [7:0]  power_control_status;
   reg  [20:0] tos_shadow;
   reg         tos_dirty;
   reg         ack;
   reg  [4:0]  tos_addr;

   // Next values of the registered state
   reg  [20:0] next_pc;
   reg  [7:0]  next_high_latch;
   reg  [7:0]  next_upper_latch;
   reg  [20:0] next_tos_shadow;
   reg         next_tos_dirty;
   reg  [4:0]  next_tos_addr;
   reg  [7:0]  next_status;
   reg  [31:0] next_readdata;

   // Bus phase: one wait cycle so read data come from flip-flops
   localparam ST_IDLE = 2'b01;
   localparam ST_DONE = 2'b10;
   reg  [1:0]  state;
   reg  [1:0]  next_state;

   wire        req     = avs_read | avs_write;
   wire [3:0]  idx     = avs_address[5:2];
   wire        wr_go   = avs_write & ack;
   wire        rd_go   = avs_read & ack;
   wire        be0     = avs_byteenable[0];

   // Word-align a byte address
   function [20:0] align;
      input [20:0] a;
      begin
         align = {a[20:1], 1'b0};
      end
   endfunction

   // Zero-extend a byte field onto the 32-bit read bus
   function [31:0] widen8;
      input [7:0] b;
      begin
         widen8 = {24'h00_0000, b};
      end
   endfunction

   // Zero-extend a five-bit field onto the 32-bit read bus
   function [31:0] widen5;
      input [4:0] b;
      begin
         widen5 = {27'h000_0000, b};
      end
   endfunction

   // Bus register hits; a write needs byte lane 0, a read needs nothing
   reg         w_pcl;
   reg         w_lath;
   reg         w_latu;
   reg         w_sp;
   reg         w_top_of_stack_low;
   reg         w_top_of_stack_high;
   reg         w_top_of_stack_upper;
   reg         w_stat;
   wire        r_pcl   = rd_go & (idx == `REG_PC_LOW); // RULE6

   // One strobe per index; unmapped indexes raise none
   always @* begin
      w_pcl  = 1'b0;
      w_lath = 1'b0;
      w_latu = 1'b0;
      w_sp   = 1'b0;
      w_top_of_stack_low = 1'b0;
      w_top_of_stack_high = 1'b0;
      w_top_of_stack_upper = 1'b0;
      w_stat = 1'b0;
      if (wr_go && be0) begin
         case (idx)
            `REG_PC_LOW:         w_pcl  = 1'b1; // RULE2
            `REG_PC_HIGH_LATCH:  w_lath = 1'b1; // RULE3
            `REG_PC_UPPER_LATCH: w_latu = 1'b1; // RULE4
            `REG_STACK_PTR:      w_sp   = 1'b1; // RULE14
            `REG_TOS_LOW:        w_top_of_stack_low = 1'b1;
            `REG_TOS_HIGH:       w_top_of_stack_high = 1'b1;
            `REG_TOS_UPPER:      w_top_of_stack_upper = 1'b1;
            `REG_POWER_STATUS:   w_stat = 1'b1;
            default:             w_pcl  = 1'b0;
         endcase
      end
   end

   // Stack events from the core
   wire        push_req = core_call | core_irq_ack; // RULE11
   wire        pop_req  = core_return & ~push_req; // RULE11
   wire        full     = (stack_pointer_reg == `STACK_DEPTH);
   wire        empty    = (stack_pointer_reg == `SP_RESET);
   wire        do_push  = push_req & ~full; // RULE10
   wire        do_pop   = pop_req & ~empty;

   // Storage interface
   wire [20:0] ram_q;
   reg  [4:0]  next_sp;
   wire [20:0] pc_next_seq = align(pc_reg + 21'h00_0002); // RULE8
   wire [20:0] push_value  = core_irq_ack ? pc_reg : pc_next_seq; // RULE15
   wire        tos_pending = tos_dirty & (tos_addr == stack_pointer_reg);
   wire [20:0] tos_value   = tos_pending ? tos_shadow : ram_q; // RULE19
   wire        tos_wr      = w_top_of_stack_low | w_top_of_stack_high | w_top_of_stack_upper;
   wire        flush       = tos_dirty & ~do_push; // A push owns the port first
   wire        ram_we      = do_push | flush;
   wire [4:0]  ram_waddr   = do_push ? next_sp : tos_addr;
   wire [20:0] ram_wdata   = do_push ? push_value : tos_shadow;

   // Pointer next value: push increments first, pop decrements after use
   always @* begin
      next_sp = stack_pointer_reg;
      if (w_sp)
         next_sp = avs_writedata[4:0]; // RULE14
      else if (do_push)
         next_sp = stack_pointer_reg + 5'h01; // RULE15
      else if (do_pop)
         next_sp = stack_pointer_reg - 5'h01; // RULE16
   end

   stack_ram #(
      .WIDTH (`PC_WIDTH),
      .AW    (`SP_WIDTH),
      .DEPTH (`STACK_DEPTH)
   ) u_stack ( // RULE13
      .mclk    (mclk),
      .wr_en   (ram_we),
      .wr_addr (ram_waddr),
      .wr_data (ram_wdata),
      .rd_addr (next_sp), // RULE21
      .rd_data (ram_q)
   );

   // Bus sequencing
   always @* begin
      case (state)
         ST_IDLE: begin
            if (req)
               next_state = ST_DONE; // Answer in the next cycle
            else
               next_state = ST_IDLE;
         end
         ST_DONE: begin
            next_state = ST_IDLE; // Gap so a held request is not served twice
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         ack   <= 1'b0;
      end else begin
         state <= next_state;
         ack   <= (state == ST_IDLE) & req;
      end
   end

   // Waitrequest drops in the cycle the request is served
   assign avs_waitrequest = req & ~ack;

   // Next counter: software low-byte write wins over core flow
   always @* begin
      next_pc = pc_reg;
      if (w_pcl)
         next_pc = {pc_upper_latch[4:0], pc_high_latch,
                    avs_writedata[7:1], 1'b0}; // RULE5 RULE7 RULE2
      else if (do_pop)
         next_pc = align(tos_value); // RULE16
      else if (core_jump)
         next_pc = align(core_target); // RULE9
      else if (core_advance)
         next_pc = pc_next_seq; // RULE8
   end

   // Counter register
   always @(posedge mclk or posedge rst) begin
      if (rst)
         pc_reg <= `PC_RESET; // RULE1
      else
         pc_reg <= next_pc;
   end

   // Next latches: only software writes and low-byte reads touch them
   always @* begin
      next_high_latch  = pc_high_latch;
      next_upper_latch = pc_upper_latch;
      if (r_pcl) begin
         next_high_latch  = pc_reg[15:8]; // RULE6
         next_upper_latch = {3'b000, pc_reg[20:16]}; // RULE6
      end else begin
         if (w_lath)
            next_high_latch = avs_writedata[7:0]; // RULE3
         if (w_latu)
            next_upper_latch = {3'b000, avs_writedata[4:0]}; // RULE4
      end
   end

   // Latch registers; calls and returns never reach them
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         pc_high_latch  <= 8'h00;
         pc_upper_latch <= 8'h00;
      end else begin
         pc_high_latch  <= next_high_latch; // RULE12
         pc_upper_latch <= next_upper_latch; // RULE12
      end
   end

   // Next shadow: a top-of-stack write merges bytes into the addressed entry
   always @* begin
      next_tos_shadow = tos_shadow;
      next_tos_dirty  = tos_dirty;
      next_tos_addr   = tos_addr;
      if (tos_wr && !empty) begin
         next_tos_shadow = tos_value;
         if (w_top_of_stack_low)
            next_tos_shadow[7:0] = {avs_writedata[7:1], 1'b0}; // RULE14
         if (w_top_of_stack_high)
            next_tos_shadow[15:8] = avs_writedata[7:0]; // RULE14
         if (w_top_of_stack_upper)
            next_tos_shadow[20:16] = avs_writedata[4:0]; // RULE14
         next_tos_dirty = 1'b1;
         next_tos_addr  = stack_pointer_reg;
      end else if (flush) begin
         next_tos_dirty = 1'b0; // RULE21
      end
   end

   // Pointer and shadow; the shadow keeps its address so a push cannot lose it
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         stack_pointer_reg <= `SP_RESET; // RULE17
         tos_shadow        <= 21'h00_0000;
         tos_dirty         <= 1'b0;
         tos_addr          <= `SP_RESET;
      end else begin
         stack_pointer_reg <= next_sp;
         tos_shadow        <= next_tos_shadow;
         tos_dirty         <= next_tos_dirty;
         tos_addr          <= next_tos_addr;
      end
   end

   // Next status: sticky flags, hardware set wins over a software clear
   always @* begin
      next_status = power_control_status;
      if (w_stat)
         next_status = avs_writedata[7:0] & power_control_status;
      if (push_req && full)
         next_status[`STAT_OVF_BIT] = 1'b1; // RULE18
      if (pop_req && empty)
         next_status[`STAT_UNF_BIT] = 1'b1; // RULE18
   end

   // Status register
   always @(posedge mclk or posedge rst) begin
      if (rst)
         power_control_status <= `STAT_RESET;
      else
         power_control_status <= next_status;
   end

   // Next read word, taken in the first cycle of a read; unmapped offsets read zero
   always @* begin
      next_readdata = avs_readdata;
      if ((state == ST_IDLE) && avs_read) begin
         case (idx)
            `REG_PC_LOW:         next_readdata = widen8(pc_reg[7:0]); // RULE2
            `REG_PC_HIGH_LATCH:  next_readdata = widen8(pc_high_latch);
            `REG_PC_UPPER_LATCH: next_readdata = widen8(pc_upper_latch);
            `REG_STACK_PTR:      next_readdata = widen5(stack_pointer_reg);
            `REG_TOS_LOW:        next_readdata = widen8(tos_value[7:0]); // RULE19
            `REG_TOS_HIGH:       next_readdata = widen8(tos_value[15:8]);
            `REG_TOS_UPPER:      next_readdata = widen5(tos_value[20:16]);
            `REG_POWER_STATUS:   next_readdata = widen8(power_control_status);
            `REG_PC_FULL:        next_readdata = {11'h000, pc_reg};
            default:             next_readdata = 32'h0000_0000;
         endcase
      end
   end

   // Read data register, so the bus sees flip-flop outputs only
   always @(posedge mclk or posedge rst) begin
      if (rst)
         avs_readdata <= 32'h0000_0000;
      else
         avs_readdata <= next_readdata;
   end

   // Core-facing outputs straight from registers
   assign pc              = pc_reg;
   assign stack_pointer   = stack_pointer_reg;
   assign stack_overflow  = power_control_status[`STAT_OVF_BIT];
   assign stack_underflow = power_control_status[`STAT_UNF_BIT];
endmodule // pc_return_stack

// File: pc_stack_sva.sv
// Port checker for the program counter and return stack
`timescale 1ns/1ps
module pc_stack_sva (
   // Clock, reset, bus handshake
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   // Core strobes
   input wire logic        core_advance,
   input wire logic        core_jump,
   input wire logic        core_call,
   input wire logic        core_irq_ack,
   input wire logic        core_return,
   input wire logic [20:0] core_target,
   // Core view
   input wire logic [20:0] pc,
   input wire logic [4:0]  stack_pointer,
   input wire logic        stack_overflow,
   input wire logic        stack_underflow
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Core events; bus writes excluded since they outrank the core
   sequence s_push; (core_call || core_irq_ack) && !avs_write; endsequence
   sequence s_pop; core_return && !core_call && !core_irq_ack && !avs_write; endsequence
   sequence s_quiet;
      !core_jump && !core_return && !core_call && !core_irq_ack && !avs_write;
   endsequence
   a_reset_clear: assert property ($fell(rst) |-> stack_pointer == 5'h00 && pc == 21'h0_0000)
      else $error("state not cleared by reset");
   a_pc_aligned: assert property (pc[0] == 1'b0) else $error("pc bit zero set");
   a_advance_two: assert property (s_quiet ##0 core_advance |=> pc == $past(pc) + 21'h0_0002)
      else $error("advance not by two");
   a_jump_load: assert property (core_jump && !core_return && !avs_write
      |=> pc == ($past(core_target) & 21'h1F_FFFE)) else $error("jump target not loaded");
   a_push_step: assert property (s_push ##0 stack_pointer != 5'h1F
      |=> stack_pointer == $past(stack_pointer) + 5'h01) else $error("push pointer wrong");
   a_pop_step: assert property (s_pop ##0 stack_pointer != 5'h00
      |=> stack_pointer == $past(stack_pointer) - 5'h01) else $error("pop pointer wrong");
   a_overflow_flag: assert property (s_push ##0 stack_pointer == 5'h1F
      |=> stack_overflow && stack_pointer == 5'h1F) else $error("overflow missed");
   a_underflow_flag: assert property (s_pop ##0 stack_pointer == 5'h00 |=> stack_underflow)
      else $error("underflow missed");
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
endmodule // pc_stack_sva

// File: core_model.sv
// Behavioural core driving fetch, branch, call, interrupt and return strobes
`timescale 1ns/1ps
module core_model (
   // Clock
   input  wire logic   mclk,
   // Strobes toward the counter block
   output logic        core_advance,
   output logic        core_jump,
   output logic        core_call,
   output logic        core_irq_ack,
   output logic        core_return,
   output logic [20:0] core_target
);
   // Quiet at time zero so nothing moves before the first request
   initial begin
      {core_advance, core_jump, core_call, core_irq_ack, core_return} = 5'h00;
      core_target = 21'h0_0000;
   end
   // One strobe for one cycle; a call also jumps, and never overlaps a stack bus access
   task automatic op(input [4:0] kind, input [20:0] tgt);
      begin
         @(posedge mclk);
         {core_advance, core_jump, core_call, core_irq_ack, core_return} <= kind;
         core_target <= tgt;
         @(posedge mclk);
         {core_advance, core_jump, core_call, core_irq_ack, core_return} <= 5'h00;
         @(negedge mclk);
      end
   endtask
endmodule // core_model

// File: tb_program_counter_return_stack.sv
// Bench for the program counter and return stack block
`timescale 1ns/1ps
module tb_program_counter_return_stack;
   logic        mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [5:0]  avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
   logic [3:0]  avs_byteenable = 4'hF, lanes = 4'hF;
   logic        core_advance, core_jump, core_call, core_irq_ack, core_return;
   logic [20:0] core_target, pc;
   logic [4:0]  stack_pointer;
   logic        stack_overflow, stack_underflow;
   integer      failures = 0, samples_checked = 0, i;
   // 100 MHz core clock
   always #5 mclk = ~mclk;
   pc_return_stack i_dut (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .core_advance, .core_jump,
      .core_target, .core_call, .core_irq_ack, .core_return, .pc, .stack_pointer,
      .stack_overflow, .stack_underflow);
   core_model u_core (.mclk, .core_advance, .core_jump, .core_call, .core_irq_ack,
      .core_return, .core_target);
   task automatic end_of_test(input timed_out);
      begin
         if (timed_out) failures = failures + 1;
         $display("checks %0d, mismatches %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   task automatic check(input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
         end
      end
   endtask
   // Bus cycle held until a rising edge samples waitrequest low; read data taken there
   task automatic bus(input wr, input [3:0] idx, input [7:0] d);
      integer n;
      begin
         @(posedge mclk);
         avs_address <= {idx, 2'b00};
         avs_writedata <= {24'h00_0000, d};
         avs_byteenable <= lanes;
         avs_write <= wr;
         avs_read <= !wr;
         n = 0;
         do begin
            @(posedge mclk);
            n = n + 1;
         end while (avs_waitrequest !== 1'b0 && n < 20);
         if (avs_waitrequest !== 1'b0) end_of_test(1'b1);
         rd = avs_readdata;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
         @(negedge mclk);
      end
   endtask
   task automatic rdchk(input [3:0] idx, input [31:0] exp);
      begin
         bus(1'b0, idx, 8'h00);
         check(rd, exp);
      end
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      check(stack_pointer, 5'h00);
      // Latches reach the counter only on a low byte write
      bus(1'b1, 4'h1, 8'h12);
      check(pc, 21'h0_0000);
      bus(1'b1, 4'h2, 8'h05);
      check(pc, 21'h0_0000);
      bus(1'b1, 4'h0, 8'h35);
      rdchk(4'h8, 32'h0005_1234);
      check(pc, 21'h05_1234);
      u_core.op(5'h10, 21'h0_0000);
      check(pc, 21'h05_1236);
      $display("test latch load done");
      // Call pushes the next address, return brings it back
      u_core.op(5'h0C, 21'h0A_BC00);
      check(pc, 21'h0A_BC00);
      check(stack_pointer, 5'h01);
      rdchk(4'h4, 32'h38);
      rdchk(4'h5, 32'h12);
      rdchk(4'h6, 32'h05);
      rdchk(4'h1, 32'h12);
      u_core.op(5'h01, 21'h0_0000);
      check(pc, 21'h05_1238);
      u_core.op(5'h01, 21'h0_0000);
      rdchk(4'h7, 32'h40);
      check(stack_underflow, 1'b1);
      bus(1'b1, 4'h7, 8'h00);
      $display("test call return done");
      // Reading the low byte refreshes both latches
      u_core.op(5'h08, 21'h1F_5A41);
      rdchk(4'h0, 32'h40);
      rdchk(4'h1, 32'h5A);
      rdchk(4'h2, 32'h1F);
      // Software pointer and top entry, plus an unmapped slot
      bus(1'b1, 4'h3, 8'h05);
      bus(1'b1, 4'h4, 8'h66);
      rdchk(4'h3, 32'h05);
      rdchk(4'h4, 32'h66);
      rdchk(4'h9, 32'h00);
      // A write without byte lane 0 is ignored
      lanes = 4'h0;
      bus(1'b1, 4'h3, 8'h07);
      lanes = 4'hF;
      rdchk(4'h3, 32'h05);
      bus(1'b1, 4'h3, 8'h00);
      // Pointer zero has no entry behind it
      bus(1'b1, 4'h4, 8'h22);
      rdchk(4'h4, 32'h00);
      $display("test software access done");
      // Thirty-one interrupt entries fit, the next one overflows
      for (i = 0; i < 32; i = i + 1) begin
         u_core.op(5'h02, 21'h0_0000);
         check(stack_pointer, (i < 31) ? i + 1 : 31);
      end
      rdchk(4'h7, 32'h80);
      check(stack_overflow, 1'b1);
      $display("test overflow done");
      // Reset in mid-run clears pointer and flags
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      check({stack_underflow, stack_overflow, stack_pointer}, 7'h00);
      $display("test second reset done");
      end_of_test(1'b0);
   end
endmodule // tb_program_counter_return_stack
bind pc_return_stack pc_stack_sva i_sva (.mclk, .rst, .avs_read, .avs_write, .avs_waitrequest,
   .core_advance, .core_jump, .core_call, .core_irq_ack, .core_return, .core_target, .pc,
   .stack_pointer, .stack_overflow, .stack_underflow);
